// ==== rtl/dcsw_pkg.sv ====
package dcsw_pkg;

  // ***************************************************
  // Register map (byte addresses)
  // ***************************************************
  localparam logic [7:0] ADDR_CTRL_WORD   = 8'h00;
  localparam logic [7:0] ADDR_SPEED_REF   = 8'h04;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'h08;
  localparam logic [7:0] ADDR_OUT_FREQ    = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG      = 8'h10;
  localparam logic [7:0] ADDR_DRIVE_STATE = 8'h14;
  localparam logic [7:0] ADDR_ACTIONS     = 8'h18;

  // ***************************************************
  // Control word bit positions
  // ***************************************************
  localparam int CW_PRESET_LO  = 0;
  localparam int CW_PRESET_HI  = 1;
  localparam int CW_DC_BRAKE_N = 2;
  localparam int CW_COAST_N    = 3;
  localparam int CW_QSTOP_N    = 4;
  localparam int CW_FREEZE_N   = 5;
  localparam int CW_START      = 6;
  localparam int CW_RESET      = 7;
  localparam int CW_JOG        = 8;
  localparam int CW_RAMP2      = 9;
  localparam int CW_VALID      = 10;
  localparam int CW_RELAY      = 11;
  localparam int CW_DIGOUT     = 12;
  localparam int CW_SETUP_LO   = 13;
  localparam int CW_SETUP_HI   = 14;
  localparam int CW_REVERSE    = 15;

  // ***************************************************
  // Status word bit positions
  // ***************************************************
  localparam int SW_CTRL_READY  = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_CAN_START   = 2;
  localparam int SW_TRIP        = 3;
  localparam int SW_TRIP_LOCK   = 6;
  localparam int SW_WARNING     = 7;
  localparam int SW_AT_REF      = 8;

  // ***************************************************
  // Config register fields
  // ***************************************************
  localparam int CFG_PROFILE_LSB = 0;
  localparam int CFG_MULTI_SETUP = 8;
  localparam int CFG_REV_LSB     = 9;

  // Drive-state register fields
  localparam int DS_READY      = 0;
  localparam int DS_TRIP       = 1;
  localparam int DS_TRIP_LOCK  = 2;
  localparam int DS_WARNING    = 3;
  localparam int DS_AT_REF     = 4;
  localparam int DS_COAST_IN   = 5;
  localparam int DS_FREQ_LSB   = 16;

  // Actions register fields
  localparam int ACT_CODE_LSB  = 0;
  localparam int ACT_PRESET_LSB = 4;
  localparam int ACT_SETUP_LSB = 6;
  localparam int ACT_RAMP2     = 8;
  localparam int ACT_REVERSE   = 9;
  localparam int ACT_JOG       = 10;
  localparam int ACT_FREEZE    = 11;
  localparam int ACT_OUT_EN    = 12;
  localparam int ACT_RELAY     = 13;
  localparam int ACT_DIGOUT    = 14;

  localparam logic [7:0] PROFILE_NATIVE = 8'h01;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h0000;
  // Ignored word: stop bits released, every command and output off
  localparam logic [15:0] CW_IGNORED     = 16'h007c;

  typedef enum logic [1:0] {REV_DIGITAL, REV_SERIAL, REV_LOGIC_OR, REV_LOGIC_AND} dcsw_rev_t;
  typedef enum logic [2:0] {STOP_NONE, STOP_COAST, STOP_DC_BRAKE, STOP_QUICK, STOP_RAMP} dcsw_stop_t;

endpackage

// ==== rtl/dcsw_control_status.sv ====
`timescale 1ns/1ns
// How it works
// - Two 16-bit process words each way: control then reference; status then frequency.
// - Control word acts only when profile setting selects native drive profile.
// - Control bits 1:0 pick one of four preset references.
// - Control bit 2 low requests DC braking and stop.
// - Control bit 3 low disables the output stage at once (coast).
// - Control bit 4 low requests quick-stop ramp down.
// - Control bit 5 low freezes output frequency; only speed-up/down inputs change it.
// - While frozen, only coast, DC brake or their inputs may stop the drive.
// - Control bit 6 low ramps to stop with the selected ramp.
// - Trip reset fires only on a rising edge of control bit 7.
// - Control bit 8 high selects the jog frequency.
// - Control bit 9 chooses ramp pair one or two.
// - Control bit 10 low makes the whole control word ignored.
// - Control bits 11 and 12 drive relay and digital outputs.
// - Control bits 14:13 pick the setup when multi-setup is enabled.
// - Control bit 15 reverses only when reversing source is serial, or, and.
// - Status bit 0 is ready; bit 1 is ready with coast active.
// - Status bit 2 is high when the drive can start on command.
// - Status bit 3 is high while tripped and awaiting reset.
// - Status bit 6 reports trip lock; bits 4 and 5 read zero.
// - Status bit 7 is high when any warning is present.
// - Status bit 8 is low while speed differs from the reference.
module dcsw_control_status
  import dcsw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        coastIn,
  input  wire logic        dcBrakeIn,
  input  wire logic        stopIn,
  input  wire logic        revIn,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             relayOut,
  output logic             digitalOut,
  output logic             outputEnable,
  output logic             tripResetPulse,
  output logic [1:0]       presetSel,
  output logic [1:0]       setupSel,
  output logic             ramp2Sel,
  output logic             jogSel,
  output logic             freezeSel,
  output logic             reverseSel,
  output dcsw_stop_t       stopMode
);

  // ***************************************************
  // Bus decode
  // ***************************************************
  // Address compare shared by write decode, read mux and error flag
  function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // Registers are 16 bits wide except the 32-bit drive state; the upper half of a 16-bit register reads zero
  function automatic logic [31:0] lowWord(input logic [15:0] word);
    return {16'h0000, word};
  endfunction

  wire        setupPhase = psel && !penable;
  wire        wrStrobe   = psel && penable && pready && pwrite;
  wire        hitCtrl    = addrHit(paddr, ADDR_CTRL_WORD);
  wire        hitRef     = addrHit(paddr, ADDR_SPEED_REF);
  wire        hitCfg     = addrHit(paddr, ADDR_CONFIG);
  wire        hitState   = addrHit(paddr, ADDR_DRIVE_STATE);
  wire        hitStatus  = addrHit(paddr, ADDR_STATUS_WORD);
  wire        hitFreq    = addrHit(paddr, ADDR_OUT_FREQ);
  wire        hitActions = addrHit(paddr, ADDR_ACTIONS);
  wire        mapped     = hitCtrl || hitRef || hitCfg || hitState || hitStatus || hitFreq || hitActions;
  // Read-only and unmapped offsets never reach the register file
  wire        wrCtrl     = wrStrobe && hitCtrl;
  wire        wrRef      = wrStrobe && hitRef;
  wire        wrCfg      = wrStrobe && hitCfg;
  wire        wrState    = wrStrobe && hitState;

  // ***************************************************
  // Register storage
  // ***************************************************
  logic [15:0] ctrlWord_reg;
  logic [15:0] speedRef_reg;
  logic [15:0] config_reg;
  logic [31:0] driveState_reg;
  logic        resetBitPrev_reg;
  logic [15:0] statusWord;

  // ***************************************************
  // Control word decode
  // ***************************************************
  wire [7:0]      profileSel = config_reg[CFG_PROFILE_LSB +: 8];
  wire            multiSetup = config_reg[CFG_MULTI_SETUP];
  wire dcsw_rev_t revSrc     = dcsw_rev_t'(config_reg[CFG_REV_LSB +: 2]);
  // Ignored word leaves word actions inactive, except setup select holds and revIn can still reverse
  wire cwLive = (profileSel == PROFILE_NATIVE) && ctrlWord_reg[CW_VALID];
  wire [15:0] cw = cwLive ? ctrlWord_reg : CW_IGNORED;

  wire coastCmd   = !cw[CW_COAST_N] || coastIn;
  wire dcCmd      = !cw[CW_DC_BRAKE_N] || dcBrakeIn;
  wire freezeNow  = cwLive && !ctrlWord_reg[CW_FREEZE_N];
  // Freeze masks quick-stop and ramp stops, not coast or brake
  wire quickCmd   = !freezeNow && cwLive && !ctrlWord_reg[CW_QSTOP_N];
  wire rampCmd    = !freezeNow && ((cwLive && !ctrlWord_reg[CW_START]) || stopIn);
  wire serRev     = cw[CW_REVERSE];
  wire revNext    = (revSrc == REV_DIGITAL)   ? revIn :
                    (revSrc == REV_SERIAL)    ? serRev :
                    (revSrc == REV_LOGIC_OR)  ? (revIn || serRev) :
                                                (revIn && serRev);
  wire resetEdge  = cwLive && ctrlWord_reg[CW_RESET] && !resetBitPrev_reg;

  // ***************************************************
  // Stop-mode priority
  // ***************************************************
  // Coast outranks brake: a released output stage cannot brake
  dcsw_stop_t stopNext;
  assign stopNext = coastCmd ? STOP_COAST :
                    dcCmd    ? STOP_DC_BRAKE :
                    quickCmd ? STOP_QUICK :
                    rampCmd  ? STOP_RAMP : STOP_NONE;

  // ***************************************************
  // Status word assembly
  // ***************************************************
  wire ready     = driveState_reg[DS_READY];
  wire coastAny  = coastCmd || driveState_reg[DS_COAST_IN];
  always_comb
  begin
    statusWord                 = 16'h0000;
    statusWord[SW_CTRL_READY]  = ready;
    statusWord[SW_DRIVE_READY] = ready && coastAny;
    statusWord[SW_CAN_START]   = ready && !coastAny && !driveState_reg[DS_TRIP];
    statusWord[SW_TRIP]        = driveState_reg[DS_TRIP];
    statusWord[SW_TRIP_LOCK]   = driveState_reg[DS_TRIP_LOCK];
    statusWord[SW_WARNING]     = driveState_reg[DS_WARNING];
    statusWord[SW_AT_REF]      = driveState_reg[DS_AT_REF];
  end

  wire [15:0] actions = {1'b0, cw[CW_DIGOUT], cw[CW_RELAY], !coastCmd, freezeNow, cw[CW_JOG],
                         revNext, cw[CW_RAMP2], setupSel, cw[CW_PRESET_HI:CW_PRESET_LO], 1'b0, stopNext};

  // ***************************************************
  // Read mux
  // ***************************************************
  // Word pairs sit at adjacent addresses, lower word first
  wire [31:0] readData = hitCtrl    ? lowWord(ctrlWord_reg) :
                         hitRef     ? lowWord(speedRef_reg) :
                         hitStatus  ? lowWord(statusWord) :
                         hitFreq    ? lowWord(driveState_reg[DS_FREQ_LSB +: 16]) :
                         hitCfg     ? lowWord(config_reg) :
                         hitState   ? driveState_reg :
                         hitActions ? lowWord(actions) : 32'h0000_0000;

  // ***************************************************
  // Register file next values
  // ***************************************************
  wire [15:0] ctrlWord_next     = wrCtrl ? pwdata[15:0] : ctrlWord_reg;
  wire [15:0] speedRef_next     = wrRef ? pwdata[15:0] : speedRef_reg;
  wire [15:0] config_next       = wrCfg ? pwdata[15:0] : config_reg;
  wire [31:0] driveState_next   = wrState ? pwdata : driveState_reg;
  // Edge detector follows only a live word, so an ignored word cannot arm it
  wire        resetBitPrev_next = cwLive ? ctrlWord_reg[CW_RESET] : resetBitPrev_reg;

  // ***************************************************
  // Bus answer: no wait state, valid in the first access cycle only
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= setupPhase;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pslverr <= 1'b0;
    else
      pslverr <= setupPhase && !mapped;
  end

  // Zero outside the answer so a stale word never looks valid
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else
      prdata <= (setupPhase && !pwrite) ? readData : 32'h0000_0000;
  end

  // ***************************************************
  // Register file
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      ctrlWord_reg <= CTRL_RESET_VAL;
    else
      ctrlWord_reg <= ctrlWord_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      speedRef_reg <= 16'h0000;
    else
      speedRef_reg <= speedRef_next;
  end

  // Native profile out of reset, so only the valid bit gates the word
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      config_reg <= {8'h00, PROFILE_NATIVE};
    else
      config_reg <= config_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      driveState_reg <= 32'h0000_0000;
    else
      driveState_reg <= driveState_next;
  end

  // ***************************************************
  // Trip reset edge
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      resetBitPrev_reg <= 1'b0;
    else
      resetBitPrev_reg <= resetBitPrev_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      tripResetPulse <= 1'b0;
    else
      tripResetPulse <= resetEdge;
  end

  // ***************************************************
  // Output stage and stop mode
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      outputEnable <= 1'b0;
    else
      outputEnable <= !coastCmd;
  end

  // Reset parks the drive coasting, output stage off
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      stopMode <= STOP_COAST;
    else
      stopMode <= stopNext;
  end

  // ***************************************************
  // Reference and setup selections
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      presetSel <= 2'b00;
    else
      presetSel <= cw[CW_PRESET_HI:CW_PRESET_LO];
  end

  // Setup holds while multi-setup is off or the word is ignored
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      setupSel <= 2'b00;
    else if (multiSetup && cwLive)
      setupSel <= cw[CW_SETUP_HI:CW_SETUP_LO];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      ramp2Sel <= 1'b0;
    else
      ramp2Sel <= cw[CW_RAMP2];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      jogSel <= 1'b0;
    else
      jogSel <= cw[CW_JOG];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      freezeSel <= 1'b0;
    else
      freezeSel <= freezeNow;
  end

  // Source select sits in config; default follows the input pin
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      reverseSel <= 1'b0;
    else
      reverseSel <= revNext;
  end

  // ***************************************************
  // Output pins
  // ***************************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      relayOut <= 1'b0;
    else
      relayOut <= cw[CW_RELAY];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      digitalOut <= 1'b0;
    else
      digitalOut <= cw[CW_DIGOUT];
  end

endmodule

// ==== verif/dcsw_master_model.sv ====
`timescale 1ns/1ns
// ****************************************
// Link master: control word, then reference
// ****************************************
module dcsw_master_model
  import dcsw_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'hffffffff;
  end
  // Released lines show the inverse so a stale value cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge ref_clk);
  endtask
  task automatic sendPair(input logic [15:0] cw, input logic [15:0] spd);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, ADDR_CTRL_WORD, {16'h0000, cw}, r, e);
    xfer(1'b1, ADDR_SPEED_REF, {16'h0000, spd}, r, e);
  endtask
endmodule

// ==== verif/dcsw_monitor.sv ====
`timescale 1ns/1ns
module dcsw_monitor
  import dcsw_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        coastIn,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        outputEnable,
  input wire logic        tripResetPulse,
  input wire logic [1:0]  presetSel,
  input wire logic [1:0]  setupSel,
  input wire logic        ramp2Sel,
  input wire logic        jogSel,
  input wire logic        freezeSel,
  input wire dcsw_stop_t  stopMode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  chk_answer_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_coast_gate: assert property ((stopMode == STOP_COAST) == !outputEnable)
    else $error("coast and output stage disagree");
  chk_coast_input: assert property (coastIn [*2] |=> !outputEnable)
    else $error("coast input left output on");
  chk_reset_edge: assert property (tripResetPulse |-> $past(pready && pwrite, 2) ##1 !tripResetPulse)
    else $error("trip reset pulse without edge");
  chk_freeze_hold: assert property (freezeSel |-> !(stopMode inside {STOP_QUICK, STOP_RAMP}))
    else $error("frozen drive ramped");
  chk_selects_hold: assert property (!(psel && penable && pwrite) [*2] |=> $stable({presetSel, setupSel, ramp2Sel, jogSel}))
    else $error("selection moved without write");
  cov_freeze: cover property (freezeSel && stopMode == STOP_DC_BRAKE);
  cov_pulse: cover property (tripResetPulse);
  cov_err: cover property (pslverr);
endmodule
bind dcsw_control_status dcsw_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .coastIn(coastIn), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .outputEnable(outputEnable), .tripResetPulse(tripResetPulse), .presetSel(presetSel), .setupSel(setupSel),
  .ramp2Sel(ramp2Sel), .jogSel(jogSel), .freezeSel(freezeSel), .stopMode(stopMode));

// ==== verif/drive_control_status_words_tb.sv ====
`timescale 1ns/1ns
module drive_control_status_words_tb
  import dcsw_pkg::*;
;
  logic       ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, coastIn, dcBrakeIn, stopIn, revIn;
  logic       relayOut, digitalOut, outputEnable, tripResetPulse, ramp2Sel, jogSel, freezeSel, reverseSel;
  logic [1:0] presetSel, setupSel, setupExp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cfg, ds;
  dcsw_stop_t stopMode;
  int         errorCnt, testsRun, pulses;
  logic [15:0] tbl [13] = '{16'h047c, 16'h0474, 16'h0478, 16'h046c, 16'h043c, 16'h045c, 16'h041c,
                            16'h044c, 16'h0454, 16'h0458, 16'h0d7d, 16'h167e, 16'h057f};
  logic [15:0] edg [5] = '{16'h047c, 16'h04fc, 16'h04fc, 16'h047c, 16'h04fc};
  dcsw_control_status dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .coastIn(coastIn), .dcBrakeIn(dcBrakeIn), .stopIn(stopIn), .revIn(revIn),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .relayOut(relayOut), .digitalOut(digitalOut),
    .outputEnable(outputEnable), .tripResetPulse(tripResetPulse), .presetSel(presetSel), .setupSel(setupSel),
    .ramp2Sel(ramp2Sel), .jogSel(jogSel), .freezeSel(freezeSel), .reverseSel(reverseSel), .stopMode(stopMode));
  dcsw_master_model mst (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic wrapUp;
    if (errorCnt == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e, input string m);
    testsRun++;
    if (g !== e)
    begin
      errorCnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    mst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    mst.xfer(1'b0, a, 32'h0, r, e);
    chk({e, r}, {xe, x}, "read");
  endtask
  task automatic act(input logic [15:0] c);
    logic       lv;
    logic       rv;
    dcsw_stop_t sm;
    mst.sendPair(c, c);
    lv = (cfg[7:0] == PROFILE_NATIVE) && c[CW_VALID];
    rv = cfg[10:9] == 2'd0 ? revIn : cfg[10:9] == 2'd1 ? c[15] : cfg[10:9] == 2'd2 ? c[15] | revIn : c[15] & revIn;
    if (!c[CW_COAST_N] || coastIn) sm = STOP_COAST;
    else if (!c[CW_DC_BRAKE_N] || dcBrakeIn) sm = STOP_DC_BRAKE;
    else if (!c[CW_FREEZE_N]) sm = STOP_NONE;
    else if (!c[CW_QSTOP_N]) sm = STOP_QUICK;
    else if (!c[CW_START] || stopIn) sm = STOP_RAMP;
    else sm = STOP_NONE;
    if (lv && cfg[CFG_MULTI_SETUP]) setupExp = c[14:13];
    if (lv) chk({digitalOut, relayOut, outputEnable, freezeSel, jogSel, reverseSel, ramp2Sel, setupSel, presetSel,
      stopMode}, {c[12:11], sm != STOP_COAST, !c[CW_FREEZE_N], c[8], rv, c[9], setupExp, c[1:0], sm}, "act");
    else chk({relayOut, digitalOut, jogSel, ramp2Sel, setupSel}, {4'h0, setupExp}, "ignored");
  endtask
  always @(posedge ref_clk) if (tripResetPulse === 1'b1) pulses <= pulses + 1;
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    #400000;
    errorCnt++;
    wrapUp;
  end
  initial
  begin
    rst_b = 1'b0;
    {coastIn, dcBrakeIn, stopIn, revIn, setupExp} = 6'h00;
    cfg = 32'h1;
    repeat (16) @(posedge ref_clk);
    chk({outputEnable, stopMode}, {1'b0, STOP_COAST}, "reset");
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_CONFIG, 32'h1, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    foreach (tbl[i]) act(tbl[i]);
    rd(ADDR_SPEED_REF, 32'h057f, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      revIn <= s[0];
      cfg = 32'h101 | (s << 9);
      wr(ADDR_CONFIG, cfg);
      act(16'h847c | 16'(s << 13));
      act(16'h047c);
    end
    cfg = 32'h1;
    wr(ADDR_CONFIG, cfg);
    act(16'h647c);
    act(16'h1b7c);
    wr(ADDR_CONFIG, 32'h2);
    cfg = 32'h2;
    act(16'h1f7c);
    cfg = 32'h1;
    wr(ADDR_CONFIG, cfg);
    foreach (edg[i]) act(edg[i]);
    chk(pulses, 2, "reset edges");
    coastIn <= 1'b1;
    act(16'h047c);
    {coastIn, dcBrakeIn} <= 2'b01;
    act(16'h045c);
    {dcBrakeIn, stopIn} <= 2'b01;
    act(16'h045c);
    act(16'h047c);
    rd(ADDR_ACTIONS, 32'h0000_1204, 1'b0);
    stopIn <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      ds = (32'h1 << i) | 32'h1 | 32'(i << 16);
      wr(ADDR_DRIVE_STATE, ds);
      rd(ADDR_STATUS_WORD, {23'h0, ds[4:2], 2'b00, ds[1], ds[0] & !ds[5] & !ds[1], ds[0] & ds[5], ds[0]}, 1'b0);
      rd(ADDR_OUT_FREQ, {16'h0, ds[31:16]}, 1'b0);
    end
    wrapUp;
  end
endmodule
